//--- hdl/cell_clock_select.sv
// Register cell, combinatorial cell and paired-cell flop with their clock networks.
// Assumes clk runs at 50 MHz and all clock pins are slower, asynchronous inputs.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/10ps
`include "cell_cfg.svh"

module cell_clock_select (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Avalon-MM slave
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    // Clock pins
    input  wire logic        hardwired_clock_pin,
    input  wire logic        routed_clock_a_pin,
    input  wire logic        routed_clock_b_pin,
    input  wire logic        scan_reset_pin,
    // Cell outputs
    output logic             cell_q,
    output logic             comb_out,
    output logic             paired_cell_flop,
    output logic             io_enable
);

    logic [`CFG_W-1:0]    config_r;
    logic [`IN_W-1:0]     cell_in_r;
    logic [`ROUTE_W-1:0]  route_r;
    logic [31:0]          func_r;
    logic [31:0]          readdata_r;
    logic                 wait_r;
    logic [1:0]           hw_cnt_r;
    logic                 cell_q_r;
    logic                 comb_out_r;
    logic                 paired_r;
    logic                 io_enable_r;

    // Three-stage pin synchronisers; index 0 hardwired, 1 pin A, 2 pin B, 3 scan reset.
    logic [3:0]           sync1_r;
    logic [3:0]           sync2_r;
    logic [3:0]           sync3_r;
    logic [3:0]           level_r;
    wire  [3:0]           pin_in = {scan_reset_pin, routed_clock_b_pin,
                                    routed_clock_a_pin, hardwired_clock_pin};

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    // The scan reset pin idles high, so no false low is seen after reset.
                    sync1_r[g] <= (g == 3);
                    sync2_r[g] <= (g == 3);
                    sync3_r[g] <= (g == 3);
                    level_r[g] <= (g == 3);
                end else begin
                    sync1_r[g] <= pin_in[g];
                    sync2_r[g] <= sync1_r[g];
                    sync3_r[g] <= sync2_r[g];
                    if (sync2_r[g] == sync3_r[g]) begin
                        level_r[g] <= sync3_r[g];
                    end
                end
            end
        end
    endgenerate

    // Routed networks: pin or internal buffer, then edge detection.
    wire  routed_clock_a = config_r[`CFG_A_INT] ? cell_in_r[`IN_INT_A] : level_r[1];
    wire  routed_clock_b = config_r[`CFG_B_INT] ? cell_in_r[`IN_INT_B] : level_r[2];
    wire  hw_level       = level_r[0];
    wire  [2:0] net_now  = {routed_clock_b, routed_clock_a, hw_level};
    logic [2:0] net_prev_r;
    wire  [2:0] net_rise = net_now & ~net_prev_r;
    wire  [2:0] net_fall = ~net_now & net_prev_r;

    // Start-up suppression lets a slow power-on reset settle before the fast clock acts.
    wire  hw_bypass = config_r[`CFG_SCAN_RSV] & ~level_r[3];
    wire  hw_live   = (hw_cnt_r == `HW_SKIP) | hw_bypass;

    // Steering of routed clocks onto cell inputs; the hardwired net is not offered here.
    logic [`STEER_N-1:0] steered;
    generate
        for (g = 0; g < `STEER_N; g++) begin : g_steer
            wire [1:0] src = route_r[2*g+1:2*g];
            assign steered[g] = (src == cell_pkg::SRC_ROUTED_A) ? routed_clock_a :
                                (src == cell_pkg::SRC_ROUTED_B) ? routed_clock_b :
                                cell_in_r[g];
        end
    endgenerate

    wire  sel_a_low   = steered[0];
    wire  sel_a_high  = steered[1];
    wire  sel_b_low   = steered[2];
    wire  sel_b_high  = steered[3];
    wire  en_sel_0    = steered[4];
    wire  en_sel_1    = steered[5];
    wire  async_preset = steered[6];
    wire  async_clear = steered[7];

    // Clock selection and polarity for the register cell.
    wire  [1:0] clk_sel  = config_r[`CFG_SEL_HI:`CFG_SEL_LO];
    wire  [2:0] net_edge = config_r[`CFG_FALLING] ? net_fall : net_rise;
    logic       sel_edge;
    always_comb begin
        unique case (clk_sel)
            cell_pkg::CLK_HARD:     sel_edge = net_edge[0] & hw_live;
            cell_pkg::CLK_ROUTED_A: sel_edge = net_edge[1];
            cell_pkg::CLK_ROUTED_B: sel_edge = net_edge[2];
            default:                sel_edge = 1'b0;
        endcase
    end
    wire  cell_en  = en_sel_0 | en_sel_1;
    wire  capture  = sel_edge & cell_en;

    // Five-input function table; the fifth input may be inverted.
    wire  inv_b    = cell_in_r[`IN_DB] ^ config_r[`CFG_INV_B];
    wire  [4:0] fn_idx = {inv_b, sel_b_high, sel_b_low, sel_a_high, sel_a_low};
    wire  fn_val   = func_r[fn_idx];

    // Avalon decode.
    wire  hit_cfg  = (address == `OFF_CONFIG);
    wire  hit_in   = (address == `OFF_CELL_IN);
    wire  hit_rt   = (address == `OFF_ROUTE);
    wire  hit_fn   = (address == `OFF_FUNC);
    wire  hit_st   = (address == `OFF_STATUS);
    wire  wr_go    = write & ~wait_r;
    wire  [31:0] status_word = {24'h000000, hw_cnt_r, routed_clock_b, routed_clock_a,
                                hw_live, paired_r, comb_out_r, cell_q_r};
    wire  [31:0] rd_mux = hit_cfg ? {25'h0, config_r} :
                          hit_in  ? {19'h0, cell_in_r} :
                          hit_rt  ? {14'h0, route_r} :
                          hit_fn  ? func_r :
                          hit_st  ? status_word : 32'h00000000;

    // One wait cycle for every access keeps read data registered.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wait_r     <= 1'b1;
            readdata_r <= 32'h00000000;
        end else begin
            wait_r     <= ~((read | write) & wait_r);
            if (read & wait_r) begin
                readdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            config_r  <= `CFG_RESET;
            cell_in_r <= `IN_RESET;
            route_r   <= `ROUTE_RESET;
            func_r    <= `FUNC_RESET;
        end else if (wr_go) begin
            if (hit_cfg) config_r  <= writedata[`CFG_W-1:0];
            if (hit_in)  cell_in_r <= writedata[`IN_W-1:0];
            if (hit_rt)  route_r   <= writedata[`ROUTE_W-1:0];
            if (hit_fn)  func_r    <= writedata;
        end
    end

    // Start-up counter counts hardwired rising edges until live.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hw_cnt_r   <= 2'h0;
            net_prev_r <= 3'h0;
        end else begin
            net_prev_r <= net_now;
            if (net_rise[0] && hw_cnt_r != `HW_SKIP) begin
                hw_cnt_r <= hw_cnt_r + 2'h1;
            end
        end
    end

    // Register cell; clear and preset act on the next clk edge without waiting for the selected clock edge.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cell_q_r <= 1'b0;
            paired_r <= 1'b0;
        end else begin
            if (async_clear) begin
                cell_q_r <= 1'b0;
                paired_r <= 1'b0;
            end else if (async_preset) begin
                cell_q_r <= 1'b1;
                paired_r <= 1'b1;
            end else if (capture) begin
                cell_q_r <= cell_in_r[`IN_DATA];
                paired_r <= fn_val;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            comb_out_r  <= 1'b0;
            io_enable_r <= 1'b0;
        end else begin
            comb_out_r  <= fn_val;
            io_enable_r <= steered[8];
        end
    end

    assign readdata         = readdata_r;
    assign waitrequest      = wait_r;
    assign cell_q           = cell_q_r;
    assign comb_out         = comb_out_r;
    assign paired_cell_flop = paired_r;
    assign io_enable        = io_enable_r;

    // Checks.
    AST_CLEAR_WINS: assert property (@(posedge clk) disable iff (reset)
        async_clear |=> !cell_q_r && !paired_r)
        else $error("Clear did not force both flops low.");
    AST_PRESET: assert property (@(posedge clk) disable iff (reset)
        async_preset && !async_clear |=> cell_q_r)
        else $error("Preset did not set the cell.");
    AST_HOLD_NO_EN: assert property (@(posedge clk) disable iff (reset)
        !cell_en && !async_clear && !async_preset |=> $stable(cell_q_r))
        else $error("Cell changed without enable.");
    AST_EDGE_POL: assert property (@(posedge clk) disable iff (reset)
        clk_sel == cell_pkg::CLK_ROUTED_A && config_r[`CFG_FALLING]
        |-> sel_edge == net_fall[1])
        else $error("Falling-edge cell mistook its clock edge.");
    AST_SEL_B: assert property (@(posedge clk) disable iff (reset)
        cell_en && !async_clear && !async_preset && clk_sel == cell_pkg::CLK_ROUTED_B
        && !config_r[`CFG_FALLING] && net_rise[2]
        |=> cell_q_r == $past(cell_in_r[`IN_DATA]))
        else $error("Routed B edge did not capture data.");
    AST_STARTUP: assert property (@(posedge clk) disable iff (reset)
        clk_sel == cell_pkg::CLK_HARD && hw_cnt_r != `HW_SKIP && !hw_bypass |-> !sel_edge)
        else $error("Hardwired clock acted during start-up.");
    AST_BYPASS: assert property (@(posedge clk) disable iff (reset)
        config_r[`CFG_SCAN_RSV] && !level_r[3] && clk_sel == cell_pkg::CLK_HARD
        && !config_r[`CFG_FALLING] && net_rise[0] |-> sel_edge)
        else $error("Bypass did not enable hardwired clock.");
    AST_INT_A: assert property (@(posedge clk) disable iff (reset)
        config_r[`CFG_A_INT] |-> routed_clock_a == cell_in_r[`IN_INT_A])
        else $error("Routed A not driven from internal buffer.");
    AST_STEER: assert property (@(posedge clk) disable iff (reset)
        route_r[17:16] == cell_pkg::SRC_ROUTED_B |=> io_enable_r == $past(routed_clock_b))
        else $error("Output enable did not follow routed B.");
    AST_FUNC: assert property (@(posedge clk) disable iff (reset)
        1'b1 |=> comb_out_r == $past(func_r[fn_idx]))
        else $error("Combinatorial output wrong.");
    AST_WAIT: assert property (@(posedge clk) disable iff (reset)
        (read || write) && wait_r |=> !wait_r ##1 wait_r)
        else $error("Wait request sequence wrong.");

endmodule // cell_clock_select

//--- shared/cell_cfg.svh
// Offsets, field positions and counts for the register cell and clock select block.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
`ifndef CELL_CFG_SVH
`define CELL_CFG_SVH

`define ADDR_W        5
`define OFF_CONFIG    5'h00
`define OFF_CELL_IN   5'h04
`define OFF_ROUTE     5'h08
`define OFF_FUNC      5'h0c
`define OFF_STATUS    5'h10

`define CFG_W         7
`define CFG_FALLING   0
`define CFG_SEL_LO    1
`define CFG_SEL_HI    2
`define CFG_A_INT     3
`define CFG_B_INT     4
`define CFG_SCAN_RSV  5
`define CFG_INV_B     6
`define CFG_RESET     7'h00

`define IN_W          13
`define IN_DATA       9
`define IN_DB         10
`define IN_INT_A      11
`define IN_INT_B      12
`define IN_RESET      13'h0000

`define STEER_N       9
`define ROUTE_W       18
`define ROUTE_RESET   18'h00000
`define FUNC_RESET    32'h00000000

`define HW_SKIP       2'h3

`endif

//--- shared/cell_pkg.sv
// Types shared by the register cell and clock select block.
// Assumes cell_cfg.svh carries the numeric constants.
package cell_pkg;

    typedef enum logic [1:0] {
        CLK_HARD     = 2'b00,
        CLK_ROUTED_A = 2'b01,
        CLK_ROUTED_B = 2'b10
    } clk_src_t;

    typedef enum logic [1:0] {
        SRC_SOFT     = 2'b00,
        SRC_ROUTED_A = 2'b01,
        SRC_ROUTED_B = 2'b10
    } route_src_t;

endpackage

//--- verification/clock_source_model.sv
// Board clock sources driving the hardwired and the two routed clock pins.
// Assumes the bench asks for one pulse per pin with a one-cycle request.
`timescale 1ns/10ps
module clock_source_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Pulse requests, one bit per pin
    input  wire logic [2:0] fire,
    // Board clock pins
    output logic            hardwired_clock_pin,
    output logic            routed_clock_a_pin,
    output logic            routed_clock_b_pin
);
    logic [4:0] cnt_r [3];

    always_ff @(posedge clk or posedge reset) begin
        for (int i = 0; i < 3; i++) begin
            if (reset)
                cnt_r[i] <= 5'h00;
            else if (fire[i])
                cnt_r[i] <= 5'h14;
            else if (cnt_r[i] != 5'h00)
                cnt_r[i] <= cnt_r[i] - 5'h01;
        end
    end

    // Pins stand low between pulses; each phase lasts ten cycles, well over the sync depth.
    assign hardwired_clock_pin = cnt_r[0] > 5'h0a;
    assign routed_clock_a_pin  = cnt_r[1] > 5'h0a;
    assign routed_clock_b_pin  = cnt_r[2] > 5'h0a;
endmodule // clock_source_model

//--- verification/register_cell_clock_select_tb_top.sv
// Self-checking bench for the register cell and clock select block.
// Assumes the board model supplies clock pin pulses and the bench masters the bus.
`timescale 1ns/10ps
`include "cell_cfg.svh"
module register_cell_clock_select_tb_top;
    logic        clk, reset, read, write, waitrequest, inv;
    logic [4:0]  address, sel;
    logic [31:0] writedata, readdata, q, w;
    logic        hw_pin, pin_a, pin_b, scan_reset_pin;
    logic        cell_q, comb_out, paired_cell_flop, io_enable;
    logic [2:0]  fire;
    int          n_fail, checks;

    cell_clock_select dut (.clk(clk), .reset(reset), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .hardwired_clock_pin(hw_pin), .routed_clock_a_pin(pin_a), .routed_clock_b_pin(pin_b),
        .scan_reset_pin(scan_reset_pin), .cell_q(cell_q), .comb_out(comb_out),
        .paired_cell_flop(paired_cell_flop), .io_enable(io_enable));
    clock_source_model board (.clk(clk), .reset(reset), .fire(fire),
        .hardwired_clock_pin(hw_pin), .routed_clock_a_pin(pin_a), .routed_clock_b_pin(pin_b));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic conclude();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The request stands until waitrequest is sampled low, for at most 50 cycles before the bench fails and ends.
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        address   <= a;
        write     <= wr;
        read      <= !wr;
        writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 50);
        q = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        if (n >= 50) begin
            n_fail++;
            conclude();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic fire_pin(input logic [2:0] f);
        @(posedge clk) fire <= f;
        @(posedge clk) fire <= 3'h0;
    endtask

    task automatic rst();
        reset <= 1'b1;
        repeat (5) @(posedge clk);
        reset <= 1'b0;
    endtask

    function automatic logic exp_comb(input logic [31:0] f, input logic [4:0] s, input logic i);
        return f[{s[4] ^ i, s[3:0]}];
    endfunction

    initial begin
        {reset, read, write, address, writedata, fire} = '0;
        scan_reset_pin = 1'b1;
        reset = 1'b1;
        void'($urandom(38));
        rst();
        bus(0, `OFF_CONFIG, 32'h0);
        chk(q, 32'h0);
        bus(0, `OFF_ROUTE, 32'h0);
        chk(q, 32'h0);
        bus(1, 5'h14, 32'hffffffff);
        bus(0, 5'h14, 32'h0);
        chk(q, 32'h0);
        bus(1, `OFF_CELL_IN, 32'h210);
        for (int i = 1; i <= 4; i++) begin
            fire_pin(3'h1);
            cyc(22);
            chk(cell_q, i == 4);
            bus(0, `OFF_STATUS, 32'h0);
            chk(q[3], i >= 3);
            chk(q[7:6], 32'((i < 3) ? i : 3));
        end
        rst();
        scan_reset_pin <= 1'b0;
        bus(1, `OFF_CONFIG, 32'h20);
        bus(1, `OFF_CELL_IN, 32'h210);
        fire_pin(3'h1);
        cyc(22);
        chk(cell_q, 1'b1);
        scan_reset_pin <= 1'b1;
        bus(1, `OFF_CELL_IN, 32'hc0);
        cyc(3);
        chk(cell_q, 1'b0);
        bus(1, `OFF_CELL_IN, 32'h40);
        cyc(3);
        chk(cell_q, 1'b1);
        chk(paired_cell_flop, 1'b1);
        bus(1, `OFF_CELL_IN, 32'h80);
        cyc(3);
        chk(cell_q, 1'b0);
        rst();
        bus(1, `OFF_FUNC, 32'hffffffff);
        for (int pol = 0; pol < 2; pol++) begin
            bus(1, `OFF_CONFIG, 32'h2 | 32'(pol));
            bus(1, `OFF_CELL_IN, 32'h80);
            bus(1, `OFF_CELL_IN, 32'h200);
            fire_pin(3'h2);
            cyc(22);
            chk(cell_q, 1'b0);
            bus(1, `OFF_CELL_IN, 32'h220);
            fire_pin(3'h2);
            cyc(8);
            chk(cell_q, pol == 0);
            cyc(14);
            chk(cell_q, 1'b1);
            chk(paired_cell_flop, 1'b1);
        end
        bus(1, `OFF_CONFIG, 32'h4);
        bus(1, `OFF_CELL_IN, 32'h80);
        bus(1, `OFF_CELL_IN, 32'h210);
        fire_pin(3'h2);
        cyc(22);
        chk(cell_q, 1'b0);
        fire_pin(3'h4);
        cyc(22);
        chk(cell_q, 1'b1);
        bus(1, `OFF_FUNC, 32'haaaaaaaa);
        bus(1, `OFF_ROUTE, 32'h10001);
        bus(1, `OFF_CONFIG, 32'h18);
        for (int lv = 1; lv >= 0; lv--) begin
            bus(1, `OFF_CELL_IN, (32'(lv) << 11) | (32'(1 - lv) << 12));
            cyc(8);
            chk(io_enable, 32'(lv));
            chk(comb_out, 32'(lv));
            bus(0, `OFF_STATUS, 32'h0);
            chk(q[5:4], 32'({1'(1 - lv), 1'(lv)}));
        end
        bus(1, `OFF_CONFIG, 32'h8);
        bus(1, `OFF_ROUTE, 32'h20000);
        fire_pin(3'h4);
        cyc(8);
        chk(io_enable, 1'b1);
        cyc(14);
        chk(io_enable, 1'b0);
        w = $urandom;
        bus(1, `OFF_FUNC, w);
        bus(0, `OFF_FUNC, 32'h0);
        chk(q, w);
        bus(1, `OFF_ROUTE, 32'h0);
        for (int i = 0; i < 12; i++) begin
            sel = (i == 0) ? 5'h1f : 5'($urandom);
            inv = (i == 0) ? 1'b1 : 1'($urandom);
            bus(1, `OFF_CONFIG, 32'(inv) << 6);
            bus(1, `OFF_CELL_IN, 32'(sel[3:0]) | (32'(sel[4]) << 10));
            cyc(3);
            chk(comb_out, exp_comb(w, sel, inv));
        end
        conclude();
    end
endmodule // register_cell_clock_select_tb_top
